// ==== include/sspl_pkg.sv ====
// ----------------------------------------------------------------
// Line control constants
// ----------------------------------------------------------------
package sspl_pkg;

  // ----------------------------------------------------------------
  // Register offsets, relative to the I/O base
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_P1_DATA  = 16'h0000; // Controller port 1 data
  localparam logic [15:0] OFS_P2_DATA  = 16'h0002; // Controller port 2 data
  localparam logic [15:0] OFS_P1_CTRL  = 16'h0004; // Controller port 1 control
  localparam logic [15:0] OFS_P2_CTRL  = 16'h0006; // Controller port 2 control
  localparam logic [15:0] OFS_STATUS   = 16'h0101; // Board status
  localparam logic [15:0] OFS_LINE_SEL = 16'h0106; // line_standard_select
  localparam logic [15:0] OFS_DIFF_EN  = 16'h010a; // diff_driver_enable
  localparam logic [15:0] OFS_TXCI_EN  = 16'h0304; // tx_clock_input_enable
  localparam logic [15:0] OFS_TXCO_EN  = 16'h0306; // tx_clock_output_enable
  localparam logic [15:0] OFS_IDENT    = 16'h030c; // hardware_identify_select
  localparam logic [15:0] SCC_SPAN_MAX = 16'h0006; // Last controller address

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_BIT       = 0;    // Only live bit of a control reg
  localparam int         STAT_IDENT_BIT = 3;    // Identify answer in status
  localparam int         STAT_RXACT_BIT = 0;    // Receive clock seen lately
  localparam logic       CTRL_RST       = 1'b0; // All control bits reset low
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00; // Read of a hole

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_NS      = 10;   // 100 MHz bus clock
  localparam int         RX_IDLE_NS      = 2000; // No receive edge this long
  localparam logic [7:0] RX_IDLE_CYCLES  = 8'(RX_IDLE_NS / SYS_CLK_NS);

  // ----------------------------------------------------------------
  // Port 1 line arrangement, Gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ASYNC   = 2'h0, // Handshake lines as RTS/CTS
    MODE_SE_OUT  = 2'h1, // Single-ended, we source tx clock
    MODE_SE_IN   = 2'h3, // Single-ended, peer sources tx clock
    MODE_DIFF    = 2'h2  // Differential, tx clock never taken from DCD
  } sspl_mode_t;

endpackage : sspl_pkg

// ==== sim/sspl_peer_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial peer: bit clock on the CTS pair and the DCD line
// ----------------------------------------------------------------
module sspl_peer_model (
  // Controls from the bench
  input  wire logic run,
  input  wire logic cts_lvl,
  // Lines toward port 1
  output logic      rx_clock_in,
  output logic      cts_se,
  output logic      cts_diff,
  output logic      tx_clock_in
);
  logic clk_q = 1'b0; // Peer bit clock, stands low between frames

  // 160 ns bit clock, only while a frame runs
  always begin
    #80;
    clk_q = run ? ~clk_q : 1'b0;
  end

  // Peer always supplies the receive clock in sync frames
  assign rx_clock_in = clk_q;
  // CTS pair carries the clock in frames, a handshake level otherwise
  assign cts_se      = run ? clk_q : cts_lvl;
  assign cts_diff    = run ? clk_q : cts_lvl;
  // Peer also offers its clock on DCD; the port decides whether to use it
  assign tx_clock_in = clk_q;
endmodule : sspl_peer_model

// ==== sim/tb_sync_serial_port_line_control.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the port 1 line control
// ----------------------------------------------------------------
module tb_sync_serial_port_line_control
  import sspl_pkg::*;
;
  // ----------------------------------------------------------------
  // Pins and bench state
  // ----------------------------------------------------------------
  logic        sys_clk     = 1'b0;  // Bus clock
  logic        reset_n     = 1'b0;  // Async reset
  logic [15:0] io_base     = 16'h0000; // Moved to random values later
  logic [15:0] io_addr     = 16'h0000;
  logic        io_rd_req   = 1'b0;
  logic        io_wr_req   = 1'b0;
  logic [7:0]  io_wdata    = 8'h00;
  logic [7:0]  scc_rdata   = 8'h00;  // Controller read data stand-in
  logic        scc_txc_out = 1'b0;   // Controller line levels
  logic        scc_rts1    = 1'b0;
  logic        scc_rts2    = 1'b0;
  logic        p2_cts      = 1'b0;
  logic        run         = 1'b0;   // Peer frame in progress
  logic        cts_lvl     = 1'b0;   // Peer handshake level
  logic [7:0]  io_rdata_q, scc_wdata_q;
  logic [1:0]  scc_idx_q;
  logic        io_ack_q, scc_cs_q, scc_wr_q, scc_rd_q, scc_txc_in_q, scc_rxc_in_q;
  logic        scc_cts1_q, scc_cts2_q, rts_se_q, rts_se_oe_q, rts_diff_a_q;
  logic        rts_diff_b_q, rts_diff_oe_q, p2_rts_q;
  logic        rx_clock_in, cts_se, cts_diff, tx_clock_in;
  logic [3:0]  mode;                 // {line sel, drv en, tx in, tx out}
  logic [7:0]  rd;
  logic [7:0]  ctl [int];            // Control register model by offset
  logic [31:0] rng_state   = 32'd10499;
  int          miscompares = 0;
  int          check_count = 0;
  logic [15:0] reg_ofs [4] = '{OFS_LINE_SEL, OFS_DIFF_EN, OFS_TXCI_EN, OFS_TXCO_EN};
  logic [15:0] rd_ofs [7]  = '{OFS_LINE_SEL, OFS_DIFF_EN, OFS_TXCI_EN, OFS_TXCO_EN,
                               OFS_IDENT, OFS_STATUS, 16'h0001};
  // Async, three sync arrangements, and diff with tx in (must not route)
  logic [3:0]  modes [5]   = '{4'b0000, 4'b0001, 4'b0011, 4'b1101, 4'b1111};

  // Bus clock, 100 MHz
  always #5 sys_clk = ~sys_clk;

  sspl_line_ctrl dut (
    .sys_clk, .reset_n, .io_base, .io_addr, .io_rd_req, .io_wr_req, .io_wdata,
    .io_rdata_q, .io_ack_q, .scc_cs_q, .scc_wr_q, .scc_rd_q, .scc_idx_q,
    .scc_wdata_q, .scc_rdata, .scc_txc_out, .scc_rts1, .scc_rts2, .scc_txc_in_q,
    .scc_rxc_in_q, .scc_cts1_q, .scc_cts2_q, .rx_clock_in, .cts_se, .cts_diff,
    .tx_clock_in, .rts_se_q, .rts_se_oe_q, .rts_diff_a_q, .rts_diff_b_q,
    .rts_diff_oe_q, .p2_cts, .p2_rts_q
  );

  sspl_peer_model peer (
    .run, .cts_lvl, .rx_clock_in, .cts_se, .cts_diff, .tx_clock_in
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Xorshift source, fixed start
  function automatic logic [31:0] rng();
    rng_state ^= rng_state << 13;
    rng_state ^= rng_state >> 17;
    rng_state ^= rng_state << 5;
    return rng_state;
  endfunction : rng

  // Expected read of a local offset from the model
  function automatic logic [7:0] exp_rd(input logic [15:0] ofs);
    if (ctl.exists(int'(ofs))) return ctl[int'(ofs)];
    if (ofs == OFS_STATUS) return {4'h0, ctl[int'(OFS_IDENT)][0], 3'h0};
    return 8'h00; // Holes read zero
  endfunction : exp_rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chk1

  // Inputs always change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // One bus transfer; offset is relative to io_base
  task automatic bus(input logic wr, input logic [15:0] ofs, input logic [7:0] wd,
                     output logic [7:0] rdv);
    logic sel;
    sel = (ofs[0] == 1'b0) && (ofs <= SCC_SPAN_MAX);
    rdv = 8'h00;
    tick(1);
    io_addr = io_base + ofs;
    io_wdata = wd;
    io_wr_req = wr;
    io_rd_req = ~wr;
    tick(1);
    io_wr_req = 1'b0;
    io_rd_req = 1'b0;
    chk1(io_ack_q, ~sel);
    chk1(scc_cs_q, sel);
    if (sel) begin
      chk({scc_wr_q, scc_rd_q, 4'h0, scc_idx_q}, {wr, ~wr, 4'h0, ofs[2:1]});
      if (wr) chk(scc_wdata_q, wd);
      if (!wr) begin
        tick(1);
        chk1(io_ack_q, 1'b1);
        rdv = io_rdata_q;
      end
    end else begin
      rdv = io_rdata_q;
    end
  endtask : bus

  task automatic wr_reg(input logic [15:0] ofs, input logic [7:0] wd);
    bus(1'b1, ofs, wd, rd);
    if (ctl.exists(int'(ofs))) ctl[int'(ofs)] = {7'h0, wd[0]};
  endtask : wr_reg

  // Read every local offset; status bit 0 is the activity flag, masked
  task automatic rd_all();
    foreach (rd_ofs[k]) begin
      bus(1'b0, rd_ofs[k], 8'h00, rd);
      chk((rd_ofs[k] == OFS_STATUS) ? (rd & 8'hfe) : rd, exp_rd(rd_ofs[k]));
    end
  endtask : rd_all

  task automatic model_reset();
    foreach (reg_ofs[k]) ctl[int'(reg_ofs[k])] = 8'h00;
    ctl[int'(OFS_IDENT)] = 8'h00;
  endtask : model_reset

  // Hold lines for one clock phase and check routing once settled
  task automatic phase(input logic p);
    logic sy;
    int   n;
    sy = mode[1] | mode[0];
    n = 0;
    {scc_txc_out, scc_rts1, scc_rts2, p2_cts, cts_lvl} = {p, ~p, ~p, p, p};
    while (sy && rx_clock_in === p && n < 20) begin
      tick(1);
      n++;
    end
    while (sy && rx_clock_in !== p && n < 40) begin
      tick(1);
      n++;
    end
    if (n >= 40 || (sy && rx_clock_in !== p)) begin
      miscompares++;
      end_sim();
    end
    tick(5);
    chk1(scc_rxc_in_q, sy & p);
    chk1(scc_cts1_q, sy | p);
    chk1(scc_txc_in_q, mode[1] & ~mode[3] & p);
    if (!mode[3]) chk1(rts_se_q, mode[0] ? p : ~p);
    chk1(rts_diff_a_q, mode[0] ? p : ~p);
    chk1(rts_diff_b_q, mode[0] ? ~p : p);
    chk1(rts_se_oe_q, ~mode[3]);
    chk1(rts_diff_oe_q, mode[3] & mode[2]);
    chk1(p2_rts_q, ~p);
    chk1(scc_cts2_q, p);
  endtask : phase

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mode = 4'h0;
    model_reset();
    tick(2);
    reset_n = 1'b1;
    rd_all();
    $display("test reset done");
    // Moved base: offsets still decode relative to it
    io_base = 16'(rng());
    foreach (reg_ofs[k]) wr_reg(reg_ofs[k], 8'(rng()));
    rd_all();
    $display("test regs done");
    for (int v = 0; v < 2; v++) begin
      wr_reg(OFS_IDENT, {7'(rng()), v[0]});
      wr_reg(OFS_STATUS, 8'hff);
      rd_all();
    end
    $display("test ident done");
    io_base = 16'(rng());
    for (int i = 0; i < 4; i++) begin
      scc_rdata = 8'(rng());
      bus(1'b1, 16'(2 * i), scc_rdata ^ 8'h5a, rd);
      bus(1'b0, 16'(2 * i), 8'h00, rd);
      chk(rd, scc_rdata);
    end
    $display("test controller done");
    foreach (modes[i]) begin
      mode = modes[i];
      foreach (reg_ofs[j]) wr_reg(reg_ofs[j], {7'(rng()), mode[3 - j]});
      rd_all();
      run = mode[1] | mode[0];
      // Controller clock source follows who drives the tx clock
      if (run) bus(1'b1, OFS_P1_CTRL, mode[1] ? 8'h08 : 8'h15, rd);
      phase(1'b1);
      phase(1'b0);
      phase(1'b1);
      // Activity flag only after a running receive clock
      bus(1'b0, OFS_STATUS, 8'h00, rd);
      chk(rd & 8'h01, {7'h0, run});
      run = 1'b0;
    end
    $display("test modes done");
    // Reset after the last mode run, with the peer stopped, clears every control bit
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    model_reset();
    mode = 4'h0;
    rd_all();
    phase(1'b0);
    $display("test rereset done");
    end_sim();
  end
endmodule : tb_sync_serial_port_line_control

// ==== src/sspl_line_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Only port 1 gets synchronous clock routing
// - Sync mode: RTS carries tx clock when the output bit is set, CTS rx
// - External tx clock only when single-ended
// - Three sync arrangements; peer supplies rx clock
// - Line select bit: 0 single-ended, 1 differential
// - Driver enable bit gates differential drivers
// - Tx clock input bit routes DCD inward
// - Tx clock output bit drives RTS lines
// - Identify bit echoes in status bit 3
// - Addresses decoded against programmable base
// - Controller at even offsets 0 to 6
module sspl_line_ctrl
  import sspl_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Host I/O bus
  input  wire logic [15:0] io_base,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd_req,
  input  wire logic        io_wr_req,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata_q,
  output logic             io_ack_q,
  // Serial controller bus side
  output logic             scc_cs_q,
  output logic             scc_wr_q,
  output logic             scc_rd_q,
  output logic      [1:0]  scc_idx_q,
  output logic      [7:0]  scc_wdata_q,
  input  wire logic [7:0]  scc_rdata,
  // Serial controller line side
  input  wire logic        scc_txc_out,
  input  wire logic        scc_rts1,
  input  wire logic        scc_rts2,
  output logic             scc_txc_in_q,
  output logic             scc_rxc_in_q,
  output logic             scc_cts1_q,
  output logic             scc_cts2_q,
  // Port 1 pins
  input  wire logic        rx_clock_in,
  input  wire logic        cts_se,
  input  wire logic        cts_diff,
  input  wire logic        tx_clock_in,
  output logic             rts_se_q,
  output logic             rts_se_oe_q,
  output logic             rts_diff_a_q,
  output logic             rts_diff_b_q,
  output logic             rts_diff_oe_q,
  // Port 2 pins
  input  wire logic        p2_cts,
  output logic             p2_rts_q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       line_sel;  // 1 = differential
    logic       diff_en;   // Differential drivers on
    logic       txci_en;   // DCD carries tx clock in
    logic       txco_en;   // RTS carries tx clock out
    logic       ident;     // Identify request
    sspl_mode_t mode;      // Decoded arrangement
    logic [7:0] rdata;     // Read answer
    logic       ack;       // Answer strobe
    logic       scc_cs;    // Controller select pulse
    logic       scc_wr;    // Controller write pulse
    logic       scc_rd;    // Controller read pulse
    logic [1:0] scc_idx;   // Controller register
    logic [7:0] scc_wdata; // Controller write data
    logic       pend;      // Controller read in flight
    logic       rts_se;    // Single-ended RTS level
    logic       rts_se_oe; // Single-ended driver on
    logic       rts_a;     // Differential true leg
    logic       rts_b;     // Differential inverted leg
    logic       rts_oe;    // Differential driver on
    logic       txc_in;    // Tx clock toward controller
    logic       rxc_in;    // Rx clock toward controller
    logic       cts1;      // Port 1 CTS toward controller
    logic       p2_rts;    // Port 2 RTS level
    logic       cts2;      // Port 2 CTS toward controller
    logic       tog_prev;  // Last seen link toggle
    logic [7:0] idle_cnt;  // Cycles since receive edge
    logic       rx_act;    // Receive clock alive
  } sspl_state_t;

  sspl_state_t st_q; // Registered state
  sspl_state_t st_d; // Next state

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  // Controller hit: even offsets up to the last port register
  function automatic logic sspl_is_scc(input logic [15:0] rel);
    sspl_is_scc = (rel <= SCC_SPAN_MAX) && !rel[0];
  endfunction : sspl_is_scc

  // One of the single-bit control registers
  function automatic logic sspl_is_ctrl(input logic [15:0] rel);
    sspl_is_ctrl = (rel == OFS_LINE_SEL) || (rel == OFS_DIFF_EN) ||
                   (rel == OFS_TXCI_EN) || (rel == OFS_TXCO_EN) ||
                   (rel == OFS_IDENT);
  endfunction : sspl_is_ctrl

  // ----------------------------------------------------------------
  // Pin and controller inputs cross into the bus clock
  // ----------------------------------------------------------------
  logic       link_tog; // Toggle from the link domain
  logic [7:0] sync_v;   // Synchronised bundle
  logic       cts_se_s;
  logic       cts_diff_s;
  logic       dcd_s;
  logic       txc_out_s;
  logic       rts1_s;
  logic       rts2_s;
  logic       p2_cts_s;
  logic       tog_s;
  logic [15:0] rel;     // Address less base
  logic        sync_on; // Any synchronous arrangement

  // Receive clock edges counted on the peer's own clock
  sspl_link_mon u_link (
    .link_clk   (rx_clock_in),
    .reset_n    (reset_n),
    .edge_tog_q (link_tog)
  );

  // All foreign levels pass two flops before use
  sspl_sync2 #(.W(8)) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({cts_se, cts_diff, tx_clock_in, scc_txc_out,
                scc_rts1, scc_rts2, p2_cts, link_tog}),
    .sync_out (sync_v)
  );

  assign {cts_se_s, cts_diff_s, dcd_s, txc_out_s,
          rts1_s, rts2_s, p2_cts_s, tog_s} = sync_v;

  assign rel     = 16'(io_addr - io_base);
  assign sync_on = st_q.txci_en || st_q.txco_en;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic cts_src; // CTS pin of the chosen standard
    logic rts_src; // Handshake or tx clock
    cts_src = 1'b0;
    rts_src = 1'b0;
    st_d = st_q;
    // Strobes last one cycle
    st_d.ack    = 1'b0;
    st_d.scc_cs = 1'b0;
    st_d.scc_wr = 1'b0;
    st_d.scc_rd = 1'b0;

    // Controller read answer one cycle after the select
    if (st_q.pend) begin
      st_d.pend  = 1'b0;
      st_d.rdata = scc_rdata;
      st_d.ack   = 1'b1;
    end else if (io_wr_req) begin
      st_d.ack = 1'b1;
      // Controller window
      if (sspl_is_scc(rel)) begin
        st_d.scc_cs    = 1'b1;
        st_d.scc_wr    = 1'b1;
        st_d.scc_idx   = rel[2:1];
        st_d.scc_wdata = io_wdata;
        st_d.ack       = 1'b0;
      end else if (rel == OFS_LINE_SEL) begin
        st_d.line_sel = io_wdata[CTRL_BIT];
      end else if (rel == OFS_DIFF_EN) begin
        st_d.diff_en = io_wdata[CTRL_BIT];
      end else if (rel == OFS_TXCI_EN) begin
        st_d.txci_en = io_wdata[CTRL_BIT];
      end else if (rel == OFS_TXCO_EN) begin
        st_d.txco_en = io_wdata[CTRL_BIT];
      end else if (rel == OFS_IDENT) begin
        st_d.ident = io_wdata[CTRL_BIT];
      end
      // Writes elsewhere are dropped
    end else if (io_rd_req) begin
      st_d.ack   = 1'b1;
      st_d.rdata = UNMAPPED_DATA;
      // Controller read waits for its data
      if (sspl_is_scc(rel)) begin
        st_d.scc_cs  = 1'b1;
        st_d.scc_rd  = 1'b1;
        st_d.scc_idx = rel[2:1];
        st_d.pend    = 1'b1;
        st_d.ack     = 1'b0;
      end else if (rel == OFS_STATUS) begin
        st_d.rdata[STAT_IDENT_BIT] = st_q.ident;
        st_d.rdata[STAT_RXACT_BIT] = st_q.rx_act;
      end else if (rel == OFS_LINE_SEL) begin
        st_d.rdata[CTRL_BIT] = st_q.line_sel;
      end else if (rel == OFS_DIFF_EN) begin
        st_d.rdata[CTRL_BIT] = st_q.diff_en;
      end else if (rel == OFS_TXCI_EN) begin
        st_d.rdata[CTRL_BIT] = st_q.txci_en;
      end else if (rel == OFS_TXCO_EN) begin
        st_d.rdata[CTRL_BIT] = st_q.txco_en;
      end else if (rel == OFS_IDENT) begin
        st_d.rdata[CTRL_BIT] = st_q.ident;
      end
    end

    // Arrangement follows the control bits
    case ({sync_on, st_q.line_sel, st_q.txci_en})
      3'b100:  st_d.mode = MODE_SE_OUT;
      3'b101:  st_d.mode = MODE_SE_IN;
      3'b110,
      3'b111:  st_d.mode = MODE_DIFF;
      default: st_d.mode = MODE_ASYNC;
    endcase

    // RTS carries the tx clock once enabled
    rts_src        = st_q.txco_en ? txc_out_s : rts1_s;
    st_d.rts_se    = rts_src;
    st_d.rts_se_oe = !st_q.line_sel;
    st_d.rts_a     = rts_src;
    st_d.rts_b     = !rts_src;
    // Differential drivers need both the standard and the gate
    st_d.rts_oe    = st_q.line_sel && st_q.diff_en;

    // CTS pin becomes the receive clock in sync modes
    cts_src     = st_q.line_sel ? cts_diff_s : cts_se_s;
    st_d.rxc_in = sync_on && cts_src;
    st_d.cts1   = sync_on ? 1'b1 : cts_src;
    // DCD feeds tx clock only single-ended; diff has no such pin
    st_d.txc_in = st_q.txci_en && !st_q.line_sel && dcd_s;

    // Port 2 keeps plain handshakes
    st_d.p2_rts = rts2_s;
    st_d.cts2   = p2_cts_s;

    // Receive activity, restarts on each link toggle
    st_d.tog_prev = tog_s;
    if (tog_s != st_q.tog_prev) begin
      st_d.idle_cnt = 8'h00;
      st_d.rx_act   = 1'b1;
    end else if (st_q.idle_cnt >= RX_IDLE_CYCLES) begin
      st_d.rx_act = 1'b0;
    end else begin
      st_d.idle_cnt = 8'(st_q.idle_cnt + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything low at reset: drivers off, async handshakes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q          <= '0;
      st_q.line_sel <= CTRL_RST;
      st_q.diff_en  <= CTRL_RST;
      st_q.txci_en  <= CTRL_RST;
      st_q.txco_en  <= CTRL_RST;
      st_q.ident    <= CTRL_RST;
      st_q.mode     <= MODE_ASYNC;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign io_rdata_q    = st_q.rdata;
  assign io_ack_q      = st_q.ack;
  assign scc_cs_q      = st_q.scc_cs;
  assign scc_wr_q      = st_q.scc_wr;
  assign scc_rd_q      = st_q.scc_rd;
  assign scc_idx_q     = st_q.scc_idx;
  assign scc_wdata_q   = st_q.scc_wdata;
  assign scc_txc_in_q  = st_q.txc_in;
  assign scc_rxc_in_q  = st_q.rxc_in;
  assign scc_cts1_q    = st_q.cts1;
  assign scc_cts2_q    = st_q.cts2;
  assign rts_se_q      = st_q.rts_se;
  assign rts_se_oe_q   = st_q.rts_se_oe;
  assign rts_diff_a_q  = st_q.rts_a;
  assign rts_diff_b_q  = st_q.rts_b;
  assign rts_diff_oe_q = st_q.rts_oe;
  assign p2_rts_q      = st_q.p2_rts;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_line_sel_store: assert property (
    (io_wr_req && !st_q.pend && rel == OFS_LINE_SEL)
      |=> st_q.line_sel == $past(io_wdata[0]) && io_ack_q)
    else $error("line select not stored");

  a_diff_drv_gate: assert property (
    (st_q.line_sel && st_q.diff_en) [*2] |-> rts_diff_oe_q)
    else $error("differential drivers not enabled");

  a_diff_drv_off: assert property (
    !st_q.diff_en |=> !rts_diff_oe_q)
    else $error("differential drivers on while gated");

  a_txc_in_gate: assert property (
    (st_q.line_sel || !st_q.txci_en) |=> !scc_txc_in_q)
    else $error("tx clock input passed when not allowed");

  a_diff_mode_txin: assert property (
    st_q.mode == MODE_DIFF |-> !scc_txc_in_q)
    else $error("tx clock input passed in differential mode");

  a_rts_clock_out: assert property (
    (st_q.txco_en && $stable(st_q.txco_en)) |=> rts_se_q == $past(txc_out_s))
    else $error("tx clock not on RTS");

  a_rx_clock_route: assert property (
    sync_on |=> scc_cts1_q && scc_rxc_in_q == $past(st_q.line_sel ?
                                             cts_diff_s : cts_se_s))
    else $error("receive clock not taken from CTS");

  a_ident_status: assert property (
    (io_rd_req && !st_q.pend && rel == OFS_STATUS)
      |=> io_ack_q && io_rdata_q[3] == $past(st_q.ident))
    else $error("identify answer wrong");

  a_ctrl_upper_zero: assert property (
    (io_rd_req && !st_q.pend && sspl_is_ctrl(rel))
      |=> io_ack_q && io_rdata_q[7:1] == 7'h00)
    else $error("upper control bits not zero");

  a_scc_read_seq: assert property (
    (io_rd_req && !st_q.pend && sspl_is_scc(rel))
      |=> (scc_cs_q && scc_rd_q && !io_ack_q) ##1 io_ack_q)
    else $error("controller read sequence wrong");

  a_scc_odd_hole: assert property (
    ((io_rd_req || io_wr_req) && !st_q.pend && rel[0]) |=> !scc_cs_q)
    else $error("odd address reached the controller");

  a_port2_plain: assert property (
    1'b1 |=> p2_rts_q == $past(rts2_s))
    else $error("port 2 RTS not plain handshake");

endmodule : sspl_line_ctrl

// ==== src/sspl_link_mon.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Receive clock monitor, runs on the peer's clock
// ----------------------------------------------------------------
module sspl_link_mon (
  // Link clock from the peer and reset
  input  wire logic link_clk,
  input  wire logic reset_n,
  // Event toggle toward the bus domain
  output logic      edge_tog_q
);
  // Flips on every rising receive clock edge; the clock may stop between
  // frames, so the bus side only watches for changes
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_tog_q <= 1'b0;
    end else begin
      edge_tog_q <= ~edge_tog_q;
    end
  end
endmodule : sspl_link_mon

// ==== src/sspl_sync2.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-stage level synchroniser
// ----------------------------------------------------------------
module sspl_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // First stage, read only by the second

  // Both stages clear on reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sspl_sync2
